// ===== design/acs_top.sv
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1 - Negative reference select routes the external negative pin when 1, ground when 0.
// RQ2 - Positive reference select routes the external positive pin when 1, supply when 0.
// RQ3 - Codes 0 to 2 leave all 13 inputs analog; each higher code makes one more digital.
// RQ4 - After power-on the port field loads 0000 if the default fuse is 1, else 0111.
// RQ5 - Unimplemented bits ignore writes and read as zero.
// RQ6 - Acquisition code 7 down to 0 gives 20,16,12,8,6,4,2,0 bit periods.
// RQ7 - Clock select picks oscillator divided by 2,8,32,4,16,64 or the RC clock.
// RQ8 - With the RC clock the start of conversion waits one instruction cycle.
// RQ9 - Conversions run in sleep only on the RC clock.
// RQ10 - Reset restores all registers, turns the converter off and aborts a conversion.
// RQ11 - On completion the result loads, go clears and the done flag sets.
// RQ12 - The result is built by successive approximation, one bit per bit period.
// RQ13 - Justify bit set puts the result low, clear puts it high, zero-filled.
// RQ14 - Go reads 1 while busy; the enable bit powers the converter.
// RQ15 - Nonzero acquisition code samples then converts; zero converts at once.
// RQ16 - A conversion takes exactly eleven bit periods.
// RQ17 - After completion the selected channel is sampled again.
module acs_top
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device status
  input wire logic port_analog_default_fuse,
  input wire logic sleep_mode,
  // Analog core
  input wire logic comp_above,
  output acs_analog_type analog,
  output logic [3:0] channel_select,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Types and storage
  typedef enum logic [1:0] {ST_IDLE, ST_RCWAIT, ST_ACQ, ST_CONV} acs_state_type;

  acs_state_type state;
  acs_state_type next_state;
  logic converter_on;
  logic [3:0] chan;
  logic [7:0] port_ref;
  logic [7:0] timing;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic conversion_done_flag;
  logic done_enable;
  logic por_loaded;
  logic [4:0] acq_count;
  logic [2:0] wait_count;
  logic tick;
  logic sar_done;
  logic [RESULT_BITS-1:0] sar_result;
  logic [RESULT_BITS-1:0] sar_trial;

  // ==========================================================
  // APB decode
  wire logic setup = psel && !penable;
  wire logic access = psel && penable;
  wire logic wr = access && pwrite;
  wire logic hit_ctrl = paddr == OFF_CTRL;
  wire logic hit_port = paddr == OFF_PORT_REF;
  wire logic hit_time = paddr == OFF_TIMING;
  wire logic hit_rhi = paddr == OFF_RES_HIGH;
  wire logic hit_rlo = paddr == OFF_RES_LOW;
  wire logic hit_stat = paddr == OFF_IRQ_STATUS;
  wire logic hit_clr = paddr == OFF_IRQ_CLEAR;
  wire logic hit_en = paddr == OFF_IRQ_ENABLE;
  wire logic hit_any = hit_ctrl | hit_port | hit_time | hit_rhi | hit_rlo
                       | hit_stat | hit_clr | hit_en;

  // Zero wait states: ready for the whole access phase
  assign pready = access;
  assign pslverr = access && !hit_any;

  // Field views
  wire logic busy = state != ST_IDLE;
  wire logic [2:0] clk_sel = timing[CLKSEL_LSB +: 3];
  wire logic [2:0] acq_code = timing[ACQ_LSB +: 3];
  wire logic [4:0] acq_target = acs_acq_periods(acq_code); // see RQ6
  wire logic use_rc = (clk_sel == CLK_RC_A) || (clk_sel == CLK_RC_B);
  wire logic right_justify = timing[JUSTIFY_BIT];
  wire logic [3:0] port_analog_config = port_ref[3:0];

  // Control write decode
  wire logic ctrl_wr = wr && hit_ctrl;
  wire logic next_on = pwdata[CTRL_ON_BIT];
  wire logic start_req = ctrl_wr && next_on && pwdata[CTRL_GO_BIT] && !busy;
  wire logic abort = ctrl_wr && !next_on; // see RQ14

  // Read data mux
  wire logic [7:0] ctrl_view = {2'b00, chan, busy, converter_on}; // see RQ14
  wire logic [7:0] rd_byte =
      hit_ctrl ? ctrl_view :
      hit_port ? (port_ref & PORT_REF_WMASK) : // see RQ5
      hit_time ? (timing & TIMING_WMASK) : // see RQ5
      hit_rhi ? result_high :
      hit_rlo ? result_low :
      hit_stat ? {7'h00, conversion_done_flag} :
      hit_en ? {7'h00, done_enable} : 8'h00;

  // Read data taken in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_ref <= REG_RESET; // see RQ10
      timing <= REG_RESET;
      chan <= 4'h0;
      done_enable <= 1'b0;
    end else begin
      if (wr && hit_port) begin
        port_ref <= pwdata[7:0] & PORT_REF_WMASK; // see RQ5
      end else if (!por_loaded) begin
        port_ref[3:0] <= port_analog_default_fuse ?
                         PORT_CFG_FUSE_SET : PORT_CFG_FUSE_CLEAR; // see RQ4
      end
      if (wr && hit_time) begin
        timing <= pwdata[7:0] & TIMING_WMASK; // see RQ5
      end
      if (ctrl_wr) begin
        chan <= pwdata[CTRL_CHAN_LSB +: 4];
      end
      if (wr && hit_en) begin
        done_enable <= pwdata[0];
      end
    end
  end

  // Fuse is captured once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_loaded <= 1'b0;
    end else begin
      por_loaded <= 1'b1;
    end
  end

  // Module enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on <= 1'b0; // see RQ10
    end else if (ctrl_wr) begin
      converter_on <= next_on; // see RQ14
    end
  end

  // ==========================================================
  // Sequencer
  wire logic acq_over = acq_count >= acq_target;
  wire logic rc_wait_over = wait_count >= 3'(TCY_CYCLES - 1);
  wire acs_state_type after_wait = (acq_target == 5'h00) ? ST_CONV : ST_ACQ; // see RQ15

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_req) begin
          next_state = use_rc ? ST_RCWAIT : after_wait; // see RQ8
        end
      end
      ST_RCWAIT: begin
        if (rc_wait_over) begin
          next_state = after_wait; // see RQ8
        end
      end
      ST_ACQ: begin
        if (acq_over) begin
          next_state = ST_CONV; // see RQ15
        end
      end
      ST_CONV: begin
        if (sar_done) begin
          next_state = ST_IDLE; // see RQ17
        end
      end
    endcase
    if (abort) begin
      next_state = ST_IDLE;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE; // see RQ10
    end else begin
      state <= next_state;
    end
  end

  // Acquisition and instruction-cycle counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_count <= 5'h00;
      wait_count <= 3'h0;
    end else begin
      acq_count <= (state == ST_ACQ) ? acq_count + {4'h0, tick} : 5'h00;
      wait_count <= (state == ST_RCWAIT) ? wait_count + 3'h1 : 3'h0;
    end
  end

  // ==========================================================
  // Bit period clock and converter core
  acs_bit_clock u_bit_clock (
    .pclk(pclk),
    .presetn(presetn),
    .run(state == ST_ACQ || state == ST_CONV),
    .clk_select(clk_sel),
    .sleep_mode(sleep_mode),
    .tick(tick)
  );

  acs_sar u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .active(state == ST_CONV),
    .tick(tick),
    .comp_above(comp_above),
    .done(sar_done),
    .result(sar_result),
    .trial_code(sar_trial)
  );

  // ==========================================================
  // Completion
  wire logic finish = sar_done && !abort;
  wire logic [15:0] right_word = {6'h00, sar_result};
  wire logic [15:0] left_word = {sar_result, 6'h00};
  wire logic [15:0] packed_word = right_justify ? right_word : left_word; // see RQ13

  // Result pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high <= 8'h00;
      result_low <= 8'h00;
    end else if (finish) begin
      result_high <= packed_word[15:8]; // see RQ11
      result_low <= packed_word[7:0];
    end
  end

  // Done flag: a new completion wins over a clear
  wire logic flag_clear = wr && hit_clr && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag <= 1'b0;
    end else if (finish) begin
      conversion_done_flag <= 1'b1; // see RQ11
    end else if (flag_clear) begin
      conversion_done_flag <= 1'b0;
    end
  end

  assign irq = conversion_done_flag && done_enable;

  // ==========================================================
  // Analog side
  wire logic [3:0] digital_count = (port_analog_config <= PORT_CFG_ALL_ANALOG_MAX) ?
                                   4'h0 : port_analog_config - PORT_CFG_ALL_ANALOG_MAX;
  wire logic [3:0] analog_limit = 4'(NUM_INPUTS) - digital_count;

  // Lowest channels stay analog, digital pins fill in from the top
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_pin
      assign analog.analog_pin_enable[gi] = 4'(gi) < analog_limit; // see RQ3
    end
  endgenerate

  // Reference routing, sampling and channel
  assign analog.neg_ref_select = port_ref[NEG_REF_BIT]; // see RQ1
  assign analog.pos_ref_select = port_ref[POS_REF_BIT]; // see RQ2
  assign analog.sample_enable = converter_on && (state != ST_CONV); // see RQ17
  assign analog.trial_code = sar_trial;
  assign channel_select = chan;

endmodule
`default_nettype wire

// ===== design/acs_pkg.sv
package acs_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int INSTR_CYCLE_NS = 160;
  localparam int TCY_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_PERIOD_NS = 1000;
  localparam int RC_CYCLES = RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CONV_BIT_PERIODS = 11;
  localparam int RESULT_BITS = 10;
  localparam int NUM_INPUTS = 13;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PORT_REF = 8'h04;
  localparam logic [7:0] OFF_TIMING = 8'h08;
  localparam logic [7:0] OFF_RES_HIGH = 8'h0c;
  localparam logic [7:0] OFF_RES_LOW = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1c;

  // ==========================================================
  // Field positions, masks and reset values
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_CHAN_LSB = 2;
  localparam int NEG_REF_BIT = 5;
  localparam int POS_REF_BIT = 4;
  localparam int JUSTIFY_BIT = 7;
  localparam int ACQ_LSB = 3;
  localparam int CLKSEL_LSB = 0;
  localparam logic [7:0] PORT_REF_WMASK = 8'h3f;
  localparam logic [7:0] TIMING_WMASK = 8'hbf;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] PORT_CFG_FUSE_SET = 4'h0;
  localparam logic [3:0] PORT_CFG_FUSE_CLEAR = 4'h7;
  localparam logic [3:0] PORT_CFG_ALL_ANALOG_MAX = 4'h2;
  localparam logic [2:0] CLK_RC_A = 3'h3;
  localparam logic [2:0] CLK_RC_B = 3'h7;

  // Analog-side control bundle
  typedef struct packed {
    logic neg_ref_select;
    logic pos_ref_select;
    logic [NUM_INPUTS-1:0] analog_pin_enable;
    logic sample_enable;
    logic [RESULT_BITS-1:0] trial_code;
  } acs_analog_type;

  // Acquisition length in bit periods
  function automatic logic [4:0] acs_acq_periods(input logic [2:0] code);
    logic [4:0] p;
    p = 5'h00;
    unique case (code)
      3'h0: p = 5'h00;
      3'h1: p = 5'h02;
      3'h2: p = 5'h04;
      3'h3: p = 5'h06;
      3'h4: p = 5'h08;
      3'h5: p = 5'h0c;
      3'h6: p = 5'h10;
      3'h7: p = 5'h14;
    endcase
    return p;
  endfunction

  // Clock cycles per bit period, minus one
  function automatic logic [6:0] acs_div_last(input logic [2:0] sel);
    logic [6:0] d;
    d = 7'(RC_CYCLES - 1);
    unique case (sel)
      3'h0: d = 7'h01;
      3'h1: d = 7'h07;
      3'h2: d = 7'h1f;
      3'h4: d = 7'h03;
      3'h5: d = 7'h0f;
      3'h6: d = 7'h3f;
      3'h3, 3'h7: d = 7'(RC_CYCLES - 1);
    endcase
    return d;
  endfunction

endpackage

// ===== design/acs_bit_clock.sv
`timescale 1ns/1ps
`default_nettype none
module acs_bit_clock
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [2:0] clk_select,
  input wire logic sleep_mode,
  // Bit period strobe
  output logic tick
);

  // ==========================================================
  // Divider
  logic [6:0] count;
  wire logic is_rc = (clk_select == CLK_RC_A) || (clk_select == CLK_RC_B);
  wire logic halted = sleep_mode && !is_rc; // see RQ9
  wire logic at_last = count >= acs_div_last(clk_select); // see RQ7

  assign tick = run && !halted && at_last;

  // Counter restarts whenever the block is idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 7'h00;
    end else if (!run || tick) begin
      count <= 7'h00;
    end else if (!halted) begin
      count <= count + 7'h01;
    end
  end

endmodule
`default_nettype wire

// ===== design/acs_sar.sv
`timescale 1ns/1ps
`default_nettype none
module acs_sar
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic active,
  input wire logic tick,
  input wire logic comp_above,
  // Results
  output logic done,
  output logic [RESULT_BITS-1:0] result,
  output logic [RESULT_BITS-1:0] trial_code
);

  // ==========================================================
  // Successive approximation
  logic [3:0] step;
  logic [RESULT_BITS-1:0] bit_mask;
  wire logic deciding = tick && (step < 4'(CONV_BIT_PERIODS - 1));

  assign done = active && tick && (step == 4'(CONV_BIT_PERIODS - 1)); // see RQ16
  assign trial_code = result | bit_mask;

  // One result bit per bit period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step <= 4'h0;
      result <= '0;
      bit_mask <= '0;
    end else if (!active) begin
      step <= 4'h0;
      result <= '0;
      bit_mask <= {1'b1, {(RESULT_BITS-1){1'b0}}};
    end else if (deciding) begin
      step <= step + 4'h1;
      if (comp_above) begin
        result <= result | bit_mask; // see RQ12
      end
      bit_mask <= bit_mask >> 1;
    end
  end

endmodule
`default_nettype wire

// ===== tb/acs_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acs_checker
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Device side
  input wire acs_analog_type analog,
  input wire logic irq
);
  // ========
  // Helpers
  wire logic acc = psel && penable;
  wire logic wr_pr = acc && pwrite && paddr == OFF_PORT_REF;
  wire logic [12:0] pins_next = (pwdata[3:0] <= 4'h2) ? 13'h1fff : 13'h1fff >> (pwdata[3:0] - 4'h2);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ========
  // Properties
  a_ready_access: assert property (pready == acc)
    else $error("pready outside access");
  a_unmapped_err: assert property (acc && paddr > OFF_IRQ_ENABLE |-> pslverr)
    else $error("no error on unmapped access");
  a_unmapped_zero: assert property (acc && !pwrite && paddr > OFF_IRQ_ENABLE |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ref_route: assert property (
    wr_pr |=> analog.neg_ref_select == $past(pwdata[5])
    && analog.pos_ref_select == $past(pwdata[4]))
    else $error("reference select mismatch");
  a_pins_write: assert property (wr_pr |=> analog.analog_pin_enable == $past(pins_next))
    else $error("pin map mismatch");
  a_pins_shape: assert property (
    (analog.analog_pin_enable & (analog.analog_pin_enable + 13'h1)) == 13'h0)
    else $error("pin map not contiguous");
  a_irq_clear: assert property (acc && pwrite && paddr == OFF_IRQ_CLEAR && pwdata[0]
    && analog.sample_enable |=> !irq)
    else $error("irq survives clear");
  a_sar_start: assert property (
    $fell(analog.sample_enable) && !$past(acc && pwrite)
    |-> analog.trial_code == 10'h200)
    else $error("bad first trial");

  c_pins_write: cover property (wr_pr);
  c_irq: cover property ($rose(irq));
  c_conv: cover property ($fell(analog.sample_enable));
  c_slverr: cover property (acc && pslverr);
endmodule

bind acs_top acs_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .analog(analog), .irq(irq));
`default_nettype wire

// ===== tb/acs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model
  import acs_pkg::*;
(
  // Analog side
  input wire acs_analog_type analog,
  input wire logic [RESULT_BITS-1:0] level,
  // Comparator
  output logic comp_above
);
  // ========
  // Comparator, noise while sampling
  wire logic ge = level >= analog.trial_code;
  assign comp_above = analog.sample_enable ? ~ge : ge;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import acs_pkg::*;
;
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic fuse = 1'b0;
  logic sleep_mode = 1'b0;
  logic [9:0] level = 10'h000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, slv, comp_above, irq;
  logic [9:0] ev;
  logic [3:0] channel_select;
  acs_analog_type analog;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int lat, want, dv, ap;

  // ========
  // Clock, design and analog core
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  acs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_analog_default_fuse(fuse), .sleep_mode(sleep_mode), .comp_above(comp_above),
    .analog(analog), .channel_select(channel_select), .irq(irq));
  acs_analog_model u_model (.analog(analog), .level(level), .comp_above(comp_above));

  // ========
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic rst(input logic f);
    presetn <= 1'b0;
    fuse <= f;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task summarize;
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  // ========
  // Scenarios
  initial begin
    rst(1'b0);
    rdchk(OFF_PORT_REF, 32'h07);
    chk(analog.analog_pin_enable, 13'h00ff);
    for (int i = 0; i < 8; i++) begin
      if (i != 1 && i != 6) rdchk(8'(i * 4), 32'h0);
    end
    // Reference selects, port map, dead bits
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, OFF_PORT_REF, {24'hffffff, 2'b11, k[0], k[1], 4'(k)});
      rdchk(OFF_PORT_REF, {26'h0, k[0], k[1], 4'(k)});
      chk(analog.neg_ref_select, k[0]);
      chk(analog.pos_ref_select, k[1]);
      chk(analog.analog_pin_enable, k < 3 ? 13'h1fff : 13'h1fff >> (k - 2));
    end
    apb(1'b1, OFF_TIMING, 32'hff);
    rdchk(OFF_TIMING, 32'hbf);
    rdchk(8'h20, 32'h0);
    chk(slv, 1'b1);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h1);
    // Every clock and acquisition code
    for (int c = 0; c < 8; c++) begin
      ev = 10'(32'h2a5 * (c + 1));
      level <= ev;
      sleep_mode <= (c == 3);
      apb(1'b1, OFF_TIMING, 32'({c[0], 1'b0, 3'(c), 3'(c)}));
      dv = (c % 4 == 3) ? RC_CYCLES : (2 << (c / 4)) << (2 * (c % 4));
      ap = (c == 0) ? 0 : (c < 4) ? 2 * c : 4 * c - 8;
      want = (c % 4 == 3 ? TCY_CYCLES : 0) + (ap + CONV_BIT_PERIODS) * dv;
      apb(1'b1, OFF_CTRL, 32'(c * 4 + 3));
      lat = 1;
      while (irq !== 1'b1 && lat < 3000) begin
        @(posedge pclk);
        #1;
        lat++;
      end
      @(posedge pclk);
      chk(lat, want);
      chk(analog.sample_enable, 1'b1);
      chk(channel_select, 4'(c));
      rdchk(OFF_CTRL, 32'(c * 4 + 1));
      rdchk(OFF_IRQ_STATUS, 32'h1);
      rdchk(OFF_RES_HIGH, c[0] ? {6'h0, ev[9:8]} : ev[9:2]);
      rdchk(OFF_RES_LOW, c[0] ? ev[7:0] : {ev[1:0], 6'h0});
      apb(1'b1, OFF_IRQ_CLEAR, 32'h1);
      chk(irq, 1'b0);
    end
    // Sleep on a divided clock freezes, interrupt masked
    sleep_mode <= 1'b1;
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0);
    apb(1'b1, OFF_TIMING, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h3);
    repeat (100) @(posedge pclk);
    rdchk(OFF_CTRL, 32'h3);
    sleep_mode <= 1'b0;
    lat = 0;
    while (rd[1] !== 1'b0 && lat < 40) begin
      apb(1'b0, OFF_CTRL, 32'h0);
      lat++;
    end
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    rdchk(OFF_IRQ_STATUS, 32'h1);
    // Reset during a long acquisition
    apb(1'b1, OFF_TIMING, 32'h3e);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h3);
    repeat (50) @(posedge pclk);
    rst(1'b1);
    chk(irq, 1'b0);
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    rdchk(OFF_TIMING, 32'h0);
    rdchk(OFF_PORT_REF, 32'h0);
    chk(analog.analog_pin_enable, 13'h1fff);
    // Clearing the enable aborts a running conversion
    apb(1'b1, OFF_TIMING, 32'h6);
    apb(1'b1, OFF_CTRL, 32'h3);
    repeat (20) @(posedge pclk);
    rdchk(OFF_CTRL, 32'h3);
    apb(1'b1, OFF_CTRL, 32'h0);
    repeat (800) @(posedge pclk);
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    chk(analog.sample_enable, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
